/* pkg/wdrl_pkg.sv */
// package: register map, reset values and constants of the reload block
package wdrl_pkg;
  // ****************************************************************
  // register addresses (12-bit register space)
  // ****************************************************************
  localparam logic [11:0] WDRL_ADDR_CTRL   = 12'hFF0; // control / reset status
  localparam logic [11:0] WDRL_ADDR_UPPER  = 12'hFF1; // reload bits 23:16
  localparam logic [11:0] WDRL_ADDR_HIGH   = 12'hFF2; // reload bits 15:8
  localparam logic [11:0] WDRL_ADDR_LOW    = 12'hFF3; // reload bits 7:0
  localparam logic [11:0] WDRL_ADDR_CALL   = 12'h07F; // calibration low byte
  // ****************************************************************
  // unlock bytes and reset values
  // ****************************************************************
  localparam logic [7:0]  WDRL_UNLOCK_1    = 8'h55;   // first unlock byte
  localparam logic [7:0]  WDRL_UNLOCK_2    = 8'hAA;   // second unlock byte
  localparam logic [7:0]  WDRL_RST_UPPER   = 8'h00;   // upper byte after reset
  localparam logic [7:0]  WDRL_RST_HIGH    = 8'h04;   // high byte after reset
  localparam logic [7:0]  WDRL_RST_LOW     = 8'h00;   // low byte after reset
  localparam logic [23:0] WDRL_NO_REFRESH  = 24'h000002; // no refresh at/below
  // ****************************************************************
  // timing: watchdog tick from the 10 kHz oscillator, in MCLK cycles
  // ****************************************************************
  localparam int          WDRL_MCLK_HZ     = 40000000; // system clock rate
  localparam int          WDRL_OSC_HZ      = 10000;    // watchdog oscillator
  localparam int          WDRL_TICK_CYC    = WDRL_MCLK_HZ / WDRL_OSC_HZ;
  // unlock sequence states, one-hot
  typedef enum logic [2:0] {
    WDRL_LK_IDLE = 3'b001,  // locked, waiting for first byte
    WDRL_LK_HALF = 3'b010,  // first byte seen
    WDRL_LK_OPEN = 3'b100   // reload registers writable
  } wdrl_lock_type;
endpackage : wdrl_pkg

/* hw/wdrl_top.sv */
// watchdog reload registers, unlock sequence and 24-bit down-counter
`timescale 1ns/1ps
// Summary of operation
// [RULE1] bytes 55 then AA unlock reload registers
// [RULE2] unlock writes store no control bits
// [RULE3] locked reload registers ignore writes
// [RULE4] control address write-only, reads reset status
// [RULE5] refresh loads concatenated 24-bit reload
// [RULE6] reload reads return live count bytes
// [RULE7] upper/high/low bytes give bits 23..0
// [RULE8] software keeps reload at least 4
// [RULE9] software loads calibration for one second
// [RULE10] calibration low byte survives every reset
// [RULE11] counter decrements at nominal 10 kHz
// [RULE12] refresh ignored once count reaches 2
// [RULE13] timeout resets or interrupts per option
// [RULE14] always-on option starts counting at reset
// [RULE15] wrong byte restarts; reload write relocks
module wdrl_top
  import wdrl_pkg::*;
#(
  parameter int TICK_CYC = wdrl_pkg::WDRL_TICK_CYC // cycles per tick
) (
  input  wire logic        MCLK,        // system clock 40 MHz
  input  wire logic        RST_N,       // async reset, active low
  input  wire logic [11:0] ADDR,        // register address
  input  wire logic        WR,          // write strobe
  input  wire logic        RD,          // read strobe
  input  wire logic [7:0]  WDATA,       // write data
  input  wire logic        REFRESH,     // refresh instruction pulse
  input  wire logic        TO_RESET_OPT,// timeout reset option
  input  wire logic        ALWAYS_ON,   // always-on option
  input  wire logic [7:0]  RST_STATUS,  // reset cause status
  input  wire logic        CAL_LOAD,    // calibration byte program
  input  wire logic [7:0]  CAL_DATA,    // calibration byte value
  output logic [7:0]       RDATA,       // registered read data
  output logic             UNLOCKED,    // reload registers writable
  output logic             RUNNING,     // counter enabled
  output logic             WDT_RESET,   // timeout system reset
  output logic             WDT_IRQ      // timeout interrupt
);
  import wdrl_pkg::*;

  // the tick counter is 16 bits wide, so longer ticks cannot be counted
  initial begin
    if (TICK_CYC < 2) $error("TICK_CYC must be at least 2");
    if (TICK_CYC > 65536) $error("TICK_CYC must be at most 65536");
  end

  // ****************************************************************
  // state
  // ****************************************************************
  wdrl_lock_type lock_reg, lock_next;     // unlock sequence
  logic [23:0] reload_reg, reload_next;   // stored reload value
  logic [23:0] count_reg, count_next;     // live count
  logic [15:0] tick_reg, tick_next;       // oscillator emulation
  logic        run_reg, run_next;         // counting enabled
  logic        started_reg, started_next; // option sampled once
  logic        tout_reg, tout_next;       // timeout held
  logic [7:0]  rdata_reg, rdata_next;     // read data
  // calibration byte has no reset: it stays as programmed (see [RULE10])
  logic [7:0]  cal_low_reg, cal_low_next; // no reset on purpose

  logic tick; // one oscillator period elapsed
  assign tick = (tick_reg == 16'(TICK_CYC - 1));

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb begin
    lock_next    = lock_reg;
    reload_next  = reload_reg;
    count_next   = count_reg;
    tick_next    = tick ? 16'h0000 : tick_reg + 16'h0001; // see [RULE11]
    run_next     = run_reg;
    started_next = 1'b1;
    tout_next    = tout_reg;
    rdata_next   = rdata_reg;
    // calibration byte: only the programming strobe changes it
    cal_low_next = CAL_LOAD ? CAL_DATA : cal_low_reg; // see [RULE10]
    // unlock sequence; stores nothing else (see [RULE2])
    if (WR && ADDR == WDRL_ADDR_CTRL) begin
      if (lock_reg == WDRL_LK_IDLE && WDATA == WDRL_UNLOCK_1)
        lock_next = WDRL_LK_HALF; // see [RULE1]
      else if (lock_reg == WDRL_LK_HALF && WDATA == WDRL_UNLOCK_2)
        lock_next = WDRL_LK_OPEN; // see [RULE1]
      else
        lock_next = WDRL_LK_IDLE; // see [RULE15]
    end else if (WR && lock_reg == WDRL_LK_OPEN) begin
      // reload writes only while open (see [RULE3])
      if (ADDR == WDRL_ADDR_UPPER) begin
        reload_next[23:16] = WDATA; // see [RULE7]
        lock_next = WDRL_LK_IDLE;   // see [RULE15]
      end else if (ADDR == WDRL_ADDR_HIGH) begin
        reload_next[15:8] = WDATA;  // see [RULE7]
        lock_next = WDRL_LK_IDLE;   // see [RULE15]
      end else if (ADDR == WDRL_ADDR_LOW) begin
        reload_next[7:0] = WDATA;   // see [RULE7]
        lock_next = WDRL_LK_IDLE;   // see [RULE15]
      end
    end
    // always-on starts counting at the first edge after reset
    if (!started_reg && ALWAYS_ON) run_next = 1'b1; // see [RULE14]
    // counter: refresh reloads unless near expiry
    if (REFRESH && count_reg > WDRL_NO_REFRESH) begin // see [RULE12]
      count_next = reload_reg; // see [RULE5]
      run_next   = 1'b1;
      tout_next  = 1'b0;
    end else if (REFRESH && !run_reg) begin
      count_next = reload_reg; // first enable
      run_next   = 1'b1;
    end else if (run_reg && tick) begin
      if (count_reg == 24'h000000) begin
        tout_next  = 1'b1;          // sticky timeout flag
        count_next = reload_reg;    // roll over, timeout stays
      end else begin
        count_next = count_reg - 24'h000001; // see [RULE11]
      end
    end
    // reads: status at control address, live count at reload bytes
    if (RD) begin
      if (ADDR == WDRL_ADDR_CTRL)
        rdata_next = RST_STATUS;       // see [RULE4]
      else if (ADDR == WDRL_ADDR_UPPER)
        rdata_next = count_reg[23:16]; // see [RULE6]
      else if (ADDR == WDRL_ADDR_HIGH)
        rdata_next = count_reg[15:8];  // see [RULE6]
      else if (ADDR == WDRL_ADDR_LOW)
        rdata_next = count_reg[7:0];   // see [RULE6]
      else if (ADDR == WDRL_ADDR_CALL)
        rdata_next = cal_low_reg;      // see [RULE10]
      else
        rdata_next = 8'h00;            // unmapped reads as zero
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      lock_reg    <= WDRL_LK_IDLE;
      reload_reg  <= {WDRL_RST_UPPER, WDRL_RST_HIGH, WDRL_RST_LOW};
      count_reg   <= {WDRL_RST_UPPER, WDRL_RST_HIGH, WDRL_RST_LOW};
      tick_reg    <= 16'h0000;
      run_reg     <= 1'b0;
      started_reg <= 1'b0;
      tout_reg    <= 1'b0;
      rdata_reg   <= 8'h00;
    end else begin
      lock_reg    <= lock_next;
      reload_reg  <= reload_next;
      count_reg   <= count_next;
      tick_reg    <= tick_next;
      run_reg     <= run_next;
      started_reg <= started_next;
      tout_reg    <= tout_next;
      rdata_reg   <= rdata_next;
    end
  end

  // calibration memory, kept across reset (see [RULE10])
  always_ff @(posedge MCLK) begin
    cal_low_reg <= cal_low_next;
  end

  // outputs, each a flip-flop
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA     <= 8'h00;
      UNLOCKED  <= 1'b0;
      RUNNING   <= 1'b0;
      WDT_RESET <= 1'b0;
      WDT_IRQ   <= 1'b0;
    end else begin
      RDATA     <= rdata_next;
      UNLOCKED  <= (lock_next == WDRL_LK_OPEN);
      RUNNING   <= run_next;
      WDT_RESET <= tout_next && TO_RESET_OPT;  // see [RULE13]
      WDT_IRQ   <= tout_next && !TO_RESET_OPT; // see [RULE13]
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  // a stray store to the locked low reload byte must leave the value alone
  a_locked_no_write: assert property ( // see [RULE3]
    @(posedge MCLK) disable iff (!RST_N)
    (WR && lock_reg != WDRL_LK_OPEN && ADDR == WDRL_ADDR_LOW)
      |=> $stable(reload_reg))
    else $error("reload changed while locked");
  // keyed on the second byte, so spaced-out key writes are covered
  a_unlock_seq: assert property ( // see [RULE1]
    @(posedge MCLK) disable iff (!RST_N)
    (WR && ADDR == WDRL_ADDR_CTRL && WDATA == WDRL_UNLOCK_2
      && lock_reg == WDRL_LK_HALF) |=> UNLOCKED)
    else $error("unlock sequence did not open");
  a_ctrl_keeps_reload: assert property ( // see [RULE2]
    @(posedge MCLK) disable iff (!RST_N)
    (WR && ADDR == WDRL_ADDR_CTRL) |=> $stable(reload_reg))
    else $error("control write changed reload");
  a_wrong_byte: assert property ( // see [RULE15]
    @(posedge MCLK) disable iff (!RST_N)
    (WR && ADDR == WDRL_ADDR_CTRL
      && !(lock_reg == WDRL_LK_IDLE && WDATA == WDRL_UNLOCK_1)
      && !(lock_reg == WDRL_LK_HALF && WDATA == WDRL_UNLOCK_2))
      |=> lock_reg == WDRL_LK_IDLE)
    else $error("wrong control byte kept sequence");
  a_refresh_load: assert property ( // see [RULE5]
    @(posedge MCLK) disable iff (!RST_N)
    (REFRESH && count_reg > WDRL_NO_REFRESH)
      |=> count_reg == $past(reload_reg))
    else $error("refresh did not load reload value");
  a_refresh_ignored: assert property ( // see [RULE12]
    @(posedge MCLK) disable iff (!RST_N)
    (REFRESH && run_reg && count_reg <= WDRL_NO_REFRESH && !tick)
      |=> count_reg == $past(count_reg))
    else $error("late refresh was taken");
  a_read_count: assert property ( // see [RULE6]
    @(posedge MCLK) disable iff (!RST_N)
    (RD && ADDR == WDRL_ADDR_LOW)
      |=> RDATA == $past(count_reg[7:0]))
    else $error("reload read not live count");
  a_read_status: assert property ( // see [RULE4]
    @(posedge MCLK) disable iff (!RST_N)
    (RD && ADDR == WDRL_ADDR_CTRL)
      |=> RDATA == $past(RST_STATUS))
    else $error("control read not reset status");
  a_relock_after: assert property ( // see [RULE15]
    @(posedge MCLK) disable iff (!RST_N)
    (WR && lock_reg == WDRL_LK_OPEN && ADDR == WDRL_ADDR_HIGH)
      |=> !UNLOCKED && reload_reg[15:8] == $past(WDATA))
    else $error("reload write did not relock");
  // expiry must raise exactly the flag that the option selects
  a_timeout_fires: assert property ( // see [RULE13]
    @(posedge MCLK) disable iff (!RST_N)
    (run_reg && tick && count_reg == 24'h000000)
      |=> WDT_RESET == $past(TO_RESET_OPT)
        && WDT_IRQ == !$past(TO_RESET_OPT))
    else $error("timeout flag not raised per option");
  a_timeout_route: assert property ( // see [RULE13]
    @(posedge MCLK) disable iff (!RST_N)
    !(WDT_RESET && WDT_IRQ))
    else $error("timeout routed both ways");
  // judged one edge later, so a release on a clock edge cannot misfire
  a_always_on_start: assert property ( // see [RULE14]
    @(posedge MCLK) disable iff (!RST_N)
    ($rose(started_reg) && $past(ALWAYS_ON)) |-> RUNNING)
    else $error("always-on did not start counting");
endmodule : wdrl_top

/* tb/wdrl_core_model.sv */
// core-side model: register writes, reads and refresh instruction
`timescale 1ns/1ps
module wdrl_core_model
  import wdrl_pkg::*;
(
  input  wire logic       mclk,   // system clock
  input  wire logic [7:0] rdata,  // read data from block
  output logic [11:0]     addr,   // register address
  output logic            wr,     // write strobe
  output logic            rd,     // read strobe
  output logic [7:0]      wdata,  // write data
  output logic            refresh // refresh pulse
);
  // ****************************************************************
  // bus cycles
  // ****************************************************************
  // idle bus at time zero, no strobes
  initial begin
    addr    = 12'h000;
    wr      = 1'b0;
    rd      = 1'b0;
    wdata   = 8'h00;
    refresh = 1'b0;
  end
  // released write data shows the inverse, never a stale copy; the address is left as is
  task automatic wr_byte(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
    wdata <= ~d;
  endtask : wr_byte
  // data is taken just after the edge that takes the strobe
  task automatic rd_byte(input logic [11:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    addr <= ~a;
    #1 d = rdata;
  endtask : rd_byte
  // two-byte key, nothing else at the control address between
  task automatic unlock;
    wr_byte(WDRL_ADDR_CTRL, WDRL_UNLOCK_1);
    wr_byte(WDRL_ADDR_CTRL, WDRL_UNLOCK_2);
  endtask : unlock
  // each byte needs a fresh key; callers keep the value at least 4
  task automatic load(input logic [7:0] u, h, l);
    unlock();
    wr_byte(WDRL_ADDR_UPPER, u);
    unlock();
    wr_byte(WDRL_ADDR_HIGH, h);
    unlock();
    wr_byte(WDRL_ADDR_LOW, l);
  endtask : load
  // one-cycle refresh instruction
  task automatic pulse_refresh;
    @(posedge mclk);
    refresh <= 1'b1;
    @(posedge mclk);
    refresh <= 1'b0;
  endtask : pulse_refresh
endmodule : wdrl_core_model

/* tb/watchdog_reload_lock_regs_bench.sv */
// bench: reset values, lock sequence, reload bytes, timeout, options
`timescale 1ns/1ps
module watchdog_reload_lock_regs_bench;
  import wdrl_pkg::*;
  localparam int TICK = 2000; // short tick keeps the run small
  logic        MCLK = 1'b0;         // system clock
  logic        RST_N = 1'b0;        // reset, active low
  logic        TO_RESET_OPT = 1'b1; // timeout response option
  logic        ALWAYS_ON = 1'b0;    // always-on option
  logic [7:0]  RST_STATUS = 8'hC3;  // reset cause byte
  logic        CAL_LOAD = 1'b0;     // calibration program pulse
  logic [7:0]  CAL_DATA = 8'h5A;    // calibration value
  logic [11:0] ADDR;                // bus address
  logic        WR, RD, REFRESH;     // bus strobes
  logic [7:0]  WDATA, RDATA;        // bus data
  logic        UNLOCKED, RUNNING, WDT_RESET, WDT_IRQ; // flags
  int          n_errors = 0;        // mismatches
  int          num_checks = 0;      // comparisons
  logic [7:0]  g;                   // last read byte
  // 40 MHz clock
  always #12.5 MCLK = ~MCLK;
  wdrl_top #(.TICK_CYC(TICK)) i_dut (.MCLK(MCLK), .RST_N(RST_N),
    .ADDR(ADDR), .WR(WR), .RD(RD), .WDATA(WDATA), .REFRESH(REFRESH),
    .TO_RESET_OPT(TO_RESET_OPT), .ALWAYS_ON(ALWAYS_ON),
    .RST_STATUS(RST_STATUS), .CAL_LOAD(CAL_LOAD), .CAL_DATA(CAL_DATA),
    .RDATA(RDATA), .UNLOCKED(UNLOCKED), .RUNNING(RUNNING),
    .WDT_RESET(WDT_RESET), .WDT_IRQ(WDT_IRQ));
  wdrl_core_model i_core (.mclk(MCLK), .rdata(RDATA), .addr(ADDR),
    .wr(WR), .rd(RD), .wdata(WDATA), .refresh(REFRESH));
  // verdict and end of run
  task automatic complete_run;
    if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  // slack allows one tick of the live count between refresh and read
  task automatic chk(input logic [7:0] got, exp, input bit slack);
    num_checks++;
    if (!(got === exp || (slack && got === exp - 8'h01))) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // bounded wait for a timeout flag
  task automatic wait_flag(input bit irq);
    for (int i = 0; i < 6 * TICK; i++) begin
      @(posedge MCLK);
      #1;
      if ((irq ? WDT_IRQ : WDT_RESET) === 1'b1) return;
    end
    n_errors++;
    $display("BAD %0t timeout flag never rose", $time);
    complete_run();
  endtask : wait_flag
  task automatic do_reset;
    RST_N <= 1'b0;
    repeat (6) @(posedge MCLK);
    RST_N <= 1'b1;
  endtask : do_reset
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset_vals;
    i_core.rd_byte(WDRL_ADDR_UPPER, g);
    chk(g, WDRL_RST_UPPER, 0);
    i_core.rd_byte(WDRL_ADDR_HIGH, g);
    chk(g, WDRL_RST_HIGH, 0);
    i_core.rd_byte(WDRL_ADDR_CTRL, g);
    chk(g, RST_STATUS, 0);
    i_core.rd_byte(12'h123, g);
    chk(g, 8'h00, 0); // unmapped address reads zero
    chk({7'h00, RUNNING}, 8'h00, 0);
  endtask : t_reset_vals
  // stray store, broken key, good key, relock after one byte
  task automatic t_lock;
    i_core.wr_byte(WDRL_ADDR_LOW, 8'h11);
    i_core.wr_byte(WDRL_ADDR_CTRL, WDRL_UNLOCK_1);
    i_core.wr_byte(WDRL_ADDR_CTRL, 8'h12);
    i_core.wr_byte(WDRL_ADDR_CTRL, WDRL_UNLOCK_2);
    @(posedge MCLK);
    #1 chk({7'h00, UNLOCKED}, 8'h00, 0);
    i_core.unlock();
    @(posedge MCLK);
    #1 chk({7'h00, UNLOCKED}, 8'h01, 0);
    i_core.rd_byte(WDRL_ADDR_CTRL, g);
    chk(g, RST_STATUS, 0);
    i_core.wr_byte(WDRL_ADDR_LOW, 8'h33);
    i_core.wr_byte(WDRL_ADDR_LOW, 8'h44);
    i_core.pulse_refresh();
    i_core.rd_byte(WDRL_ADDR_LOW, g);
    chk(g, 8'h33, 1);
  endtask : t_lock
  // byte order, then exactly one decrement per tick period
  task automatic t_bytes;
    logic [7:0] h; // low byte one tick period later
    i_core.load(8'h01, 8'h02, 8'h03);
    i_core.pulse_refresh();
    i_core.rd_byte(WDRL_ADDR_LOW, g);
    chk(g, 8'h03, 1);
    // two samples exactly TICK edges apart span exactly one tick
    repeat (TICK - 2) @(posedge MCLK);
    i_core.rd_byte(WDRL_ADDR_LOW, h);
    chk(g - h, 8'h01, 0);
    i_core.rd_byte(WDRL_ADDR_HIGH, g);
    chk(g, 8'h02, 0);
    i_core.rd_byte(WDRL_ADDR_UPPER, g);
    chk(g, 8'h01, 0);
  endtask : t_bytes
  // refresh at count 2 is ignored, then both timeout responses
  task automatic t_timeout;
    i_core.load(8'h00, 8'h00, 8'h04);
    i_core.pulse_refresh();
    g = 8'hFF;
    for (int i = 0; i < 4 * TICK && g !== 8'h02; i++)
      i_core.rd_byte(WDRL_ADDR_LOW, g);
    if (g !== 8'h02) begin
      n_errors++;
      $display("BAD %0t count never reached 2", $time);
      complete_run();
    end
    i_core.pulse_refresh();
    i_core.rd_byte(WDRL_ADDR_LOW, g);
    chk({7'h00, g < 8'h03}, 8'h01, 0);
    wait_flag(0);
    #1 chk({7'h00, WDT_IRQ}, 8'h00, 0);
    i_core.pulse_refresh();
    TO_RESET_OPT <= 1'b0;
    @(posedge MCLK);
    #1 chk({7'h00, WDT_RESET}, 8'h00, 0);
    wait_flag(1);
    #1 chk({7'h00, WDT_RESET}, 8'h00, 0);
  endtask : t_timeout
  // calibration survives reset; always-on starts without refresh
  task automatic t_cal;
    @(posedge MCLK);
    CAL_LOAD <= 1'b1;
    @(posedge MCLK);
    CAL_LOAD  <= 1'b0;
    ALWAYS_ON <= 1'b1;
    do_reset();
    repeat (2) @(posedge MCLK);
    #1 chk({7'h00, RUNNING}, 8'h01, 0);
    i_core.rd_byte(WDRL_ADDR_CALL, g);
    chk(g, 8'h5A, 0);
    // calibrated load: upper zero, high 01, calibration byte in the low byte
    i_core.load(8'h00, 8'h01, g);
    i_core.pulse_refresh();
    i_core.rd_byte(WDRL_ADDR_LOW, g);
    chk(g, 8'h5A, 1);
    i_core.rd_byte(WDRL_ADDR_HIGH, g);
    chk(g, 8'h01, 0);
  endtask : t_cal
  // main sequence
  initial begin
    do_reset();
    t_reset_vals();
    t_lock();
    t_bytes();
    t_timeout();
    t_cal();
    complete_run();
  end
endmodule : watchdog_reload_lock_regs_bench
